// ==== hdl/ics_pkg.sv ====
// Package for the isolated converter supervisor: timing, duty and state constants.
// Assumes a 50 MHz core clock; comparator results arrive as pin-level flags.
package ics_pkg;
  localparam int CLK_MHZ = 50;
  // Times in their own units
  localparam int SS_TIMEOUT_MS = 16;
  localparam int FAULT_PULSE_US = 200;
  localparam int RESTART_MS = 160;
  localparam int ON_MAX_NS = 13000;
  localparam int OFF_MIN_NS = 1500;
  // Cycle counts
  localparam int SS_TIMEOUT_CYC = SS_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int FAULT_PULSE_CYC = FAULT_PULSE_US * CLK_MHZ;
  localparam int RESTART_CYC = RESTART_MS * 1000 * CLK_MHZ;
  localparam int ON_MAX_CYC = (ON_MAX_NS * CLK_MHZ) / 1000;
  localparam int OFF_MIN_CYC = (OFF_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 24;
  // Duty in 1/1000 units: 6.5 % start, 62.5 % cap, 100 % full
  localparam logic [9:0] DUTY_START = 10'h041;
  localparam logic [9:0] DUTY_CAP = 10'h271;
  localparam logic [9:0] DUTY_FULL = 10'h3E8;
  localparam logic [9:0] DUTY_STEP = 10'h001;
  localparam int DUTY_RATE_CYC = 256;
  // Burst carrier period and sweep bands, in cycles
  localparam logic [7:0] PERIOD_LO = 8'h19;
  localparam logic [7:0] PERIOD_HI = 8'h23;
  localparam int DEGLITCH_DEF = 500;
  localparam int SYNC_N = 3;
  typedef enum logic [2:0] {
    ICS_OFF = 3'b000,
    ICS_SOFT = 3'b001,
    ICS_RUN = 3'b010,
    ICS_FAULT = 3'b011,
    ICS_WAIT = 3'b100,
    ICS_LOCK = 3'b101
  } ics_state_e;
endpackage

// ==== hdl/ics_sync.sv ====
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous level input; output changes when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module ics_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Level in and out
  input wire logic async_in,
  output logic sync_out
);
  logic [2:0] stage_reg;
  logic out_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage_reg <= 3'h0;
    end else begin
      stage_reg <= {stage_reg[1:0], async_in};
    end
  end

  // Stage one is read only by stage two
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      out_reg <= 1'b0;
    end else if (stage_reg[1] == stage_reg[2]) begin
      out_reg <= stage_reg[2];
    end
  end

  assign sync_out = out_reg;
endmodule // ics_sync
`default_nettype wire

// ==== hdl/ics_supervisor.sv ====
// Enable, soft-start, burst regulation and fault sequencing of an isolated converter.
// Assumes comparator flags from analog; enable/fault pin is open-drain (oe low drives).
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Enable pin low keeps converter off; high lets it run.
// - Input valid and enable high starts open-loop soft-start.
// - Soft-start bursts at fixed rate, duty from 6.5 % rising steadily.
// - Duty capped at 62.5 % until output passes startup threshold.
// - No regulation after 16 ms soft-start: shut down, pull pin low 200 us.
// - After timeout report, restart timer runs then soft-start retries, repeatedly.
// - Steady state: stage on below lower band, off at upper band.
// - Burst over 13 us forces off for 1.5 us, then restarts.
// - Select sampled below startup threshold: tied output 5.0 V, ground 5.5 V.
// - Select ignored afterwards until enable toggles or supply cycles.
// - Input under or over limit stops switching.
// - Input back in range resumes at once, no restart delay.
// - Output under 0.9 of set: duty limit, shutdown after deglitch.
// - After fault pulse, 160 ms timer, then fresh soft-start; hiccup.
// - Output overvoltage: clamp, duty limit, deglitch shutdown, 160 ms restart.
// - Either stage overtemperature: deglitch stop, report, retry after 160 ms.
// - Each reportable fault shutdown sinks the pin for the report time.
// - Oscillator period steps one cycle per carrier period between two bands, wrapping; restarts low each burst.
// - Fault report holds pin low 200 us on fault or timeout shutdown; input lockout stops without a report.
module ics_supervisor #(
  parameter int SS_TIMEOUT = ics_pkg::SS_TIMEOUT_CYC,
  parameter int RESTART = ics_pkg::RESTART_CYC,
  parameter int DEGLITCH = ics_pkg::DEGLITCH_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Enable/fault pin
  input wire logic enable_fault_pin_in,
  output logic enable_fault_pin_out,
  output logic enable_fault_pin_oe,
  // Comparator flags
  input wire logic input_low_flag,
  input wire logic input_high_flag,
  input wire logic output_startup_flag,
  input wire logic output_regulated_flag,
  input wire logic output_lower_band_flag,
  input wire logic output_upper_band_flag,
  input wire logic output_under_flag,
  input wire logic output_over_flag,
  input wire logic primary_overtemp_flag,
  input wire logic secondary_overtemp_flag,
  input wire logic level_select_in,
  // Power stage and status
  output logic power_stage_on,
  output logic output_overshoot_clamp,
  output logic [9:0] duty_permille,
  output logic [7:0] switch_period,
  output logic level_high_sel,
  output logic overpower_active,
  output logic low_power_mode,
  output logic fault_active
);
  import ics_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  localparam int NS = 12;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] syn;
  assign raw_in = {level_select_in, secondary_overtemp_flag, primary_overtemp_flag,
                   output_over_flag, output_under_flag, output_upper_band_flag,
                   output_lower_band_flag, output_regulated_flag, output_startup_flag,
                   input_high_flag, input_low_flag, enable_fault_pin_in};
  for (genvar i = 0; i < NS; i++) begin : g_sync
    ics_sync u_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in(raw_in[i]),
      .sync_out(syn[i])
    );
  end
  logic en_s, in_lo, in_hi, v_start, v_reg, v_lo, v_hi, v_under, v_over, t_hot, sel_s;
  assign en_s = syn[0];
  assign in_lo = syn[1];
  assign in_hi = syn[2];
  assign v_start = syn[3];
  assign v_reg = syn[4];
  assign v_lo = syn[5];
  assign v_hi = syn[6];
  assign v_under = syn[7];
  assign v_over = syn[8];
  assign t_hot = syn[9] | syn[10];
  assign sel_s = syn[11];

  ////////////////////////////////////////////////////////////////////////////
  // State and timers
  ics_state_e state_reg;
  ics_state_e state_next;
  logic [CNT_W-1:0] tmr_reg;
  logic [CNT_W-1:0] dg_reg;
  logic [7:0] rate_reg;
  logic [9:0] duty_reg;
  logic [7:0] ph_reg;
  logic [7:0] per_reg;
  logic [9:0] on_cnt_reg;
  logic [9:0] off_cnt_reg;
  logic burst_reg;
  logic opp_reg;
  logic sel_done_reg;
  logic lvl_reg;
  logic sink_reg;
  logic in_ok;
  logic fault_cond;
  logic dg_hit;
  logic ss_expire;
  logic tmr_done;
  logic en_blank;

  assign in_ok = !in_lo && !in_hi;
  assign fault_cond = v_under || v_over || t_hot;
  // Deglitch counter; a short glitch clears it
  assign dg_hit = dg_reg >= CNT_W'(DEGLITCH);
  assign ss_expire = tmr_reg >= CNT_W'(SS_TIMEOUT - 1);
  assign tmr_done = (state_reg == ICS_FAULT) ? (tmr_reg >= CNT_W'(FAULT_PULSE_CYC - 1))
                                             : (tmr_reg >= CNT_W'(RESTART - 1));
  // Own sink reads back as disable; blind until the synchroniser sees the pin again
  assign en_blank = (state_reg == ICS_FAULT) ||
                    (state_reg == ICS_WAIT && tmr_reg < CNT_W'(SYNC_N + 2));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ICS_OFF: begin
        if (en_s && in_ok) begin
          state_next = ICS_SOFT;
        end
      end
      ICS_SOFT: begin
        if (v_reg) begin
          state_next = ICS_RUN;
        end else if (ss_expire || (dg_hit && t_hot)) begin
          state_next = ICS_FAULT;
        end
      end
      ICS_RUN: begin
        if (dg_hit) begin
          state_next = ICS_FAULT;
        end
      end
      ICS_FAULT: begin
        if (tmr_done) begin
          state_next = ICS_WAIT;
        end
      end
      ICS_WAIT: begin
        if (tmr_done) begin
          state_next = ICS_SOFT;
        end
      end
      ICS_LOCK: begin
        if (in_ok) begin
          state_next = ICS_SOFT;
        end
      end
      default: state_next = ICS_OFF;
    endcase
    // Enable low (outside the blind window) and input lockout (outside ICS_FAULT) override all else
    if (state_reg != ICS_OFF && !en_blank && !en_s) begin
      state_next = ICS_OFF;
    end else if (state_reg != ICS_OFF && state_reg != ICS_FAULT && !in_ok) begin
      state_next = ICS_LOCK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= ICS_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Shared timer restarts on every state change
  always_ff @(posedge core_clk) begin
    if (sys_rst || state_next != state_reg) begin
      tmr_reg <= '0;
    end else if (tmr_reg != {CNT_W{1'b1}}) begin
      tmr_reg <= tmr_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || !fault_cond || !(state_reg == ICS_RUN || state_reg == ICS_SOFT)) begin
      dg_reg <= '0;
    end else if (!dg_hit) begin
      dg_reg <= dg_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Soft-start duty ramp and limit
  always_ff @(posedge core_clk) begin
    if (sys_rst || state_reg != ICS_SOFT) begin
      duty_reg <= DUTY_START;
      rate_reg <= 8'h00;
    end else begin
      rate_reg <= rate_reg + 8'h01;
      if (rate_reg == 8'(DUTY_RATE_CYC - 1)) begin
        if (!v_start && duty_reg >= DUTY_CAP) begin
          duty_reg <= DUTY_CAP;
        end else if (duty_reg < DUTY_FULL) begin
          duty_reg <= duty_reg + DUTY_STEP;
        end
      end
    end
  end

  // Output fault in steady state falls back to the capped duty
  logic [9:0] duty_eff;
  always_comb begin
    duty_eff = DUTY_FULL;
    if (state_reg == ICS_SOFT) begin
      duty_eff = (!v_start && duty_reg > DUTY_CAP) ? DUTY_CAP : duty_reg;
    end else if (v_under || v_over) begin
      duty_eff = DUTY_CAP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switching carrier with band sweep restarting at PERIOD_LO each burst
  logic switching;
  assign switching = (state_reg == ICS_SOFT) || (state_reg == ICS_RUN && burst_reg);

  always_ff @(posedge core_clk) begin
    if (sys_rst || !switching) begin
      ph_reg <= 8'h00;
      per_reg <= PERIOD_LO;
    end else if (ph_reg >= per_reg - 8'h01) begin
      ph_reg <= 8'h00;
      // Sweep wraps from PERIOD_HI back to PERIOD_LO; a burst shorter than one sweep spans only the low end
      per_reg <= (per_reg >= PERIOD_HI) ? PERIOD_LO : per_reg + 8'h01;
    end else begin
      ph_reg <= ph_reg + 8'h01;
    end
  end

  logic [17:0] ph_scaled;
  logic [17:0] duty_scaled;
  assign ph_scaled = 18'(ph_reg) * 18'(DUTY_FULL);
  assign duty_scaled = 18'(duty_eff) * 18'(per_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Hysteretic burst control with overpower limit
  always_ff @(posedge core_clk) begin
    if (sys_rst || state_reg != ICS_RUN) begin
      burst_reg <= 1'b0;
      opp_reg <= 1'b0;
      on_cnt_reg <= '0;
      off_cnt_reg <= '0;
    end else if (burst_reg) begin
      off_cnt_reg <= '0;
      on_cnt_reg <= on_cnt_reg + 10'h001;
      if (v_hi) begin
        burst_reg <= 1'b0;
        opp_reg <= 1'b0;
      end else if (on_cnt_reg >= 10'(ON_MAX_CYC - 1)) begin
        burst_reg <= 1'b0;
        opp_reg <= 1'b1;
      end
    end else begin
      on_cnt_reg <= '0;
      if (off_cnt_reg != 10'h3FF) begin
        off_cnt_reg <= off_cnt_reg + 10'h001;
      end
      // Off time never below the minimum, overpower or not
      if ((v_lo || opp_reg) && !v_hi && off_cnt_reg >= 10'(OFF_MIN_CYC - 1)) begin
        burst_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output level select, sampled once per enable or supply cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst || state_reg == ICS_OFF) begin
      sel_done_reg <= 1'b0;
      lvl_reg <= 1'b0;
    end else if (state_reg == ICS_SOFT && !sel_done_reg) begin
      if (!v_start) begin
        lvl_reg <= !sel_s;
      end else begin
        sel_done_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault report sink
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sink_reg <= 1'b0;
    end else begin
      sink_reg <= (state_next == ICS_FAULT);
    end
  end

  // Open-drain: oe low drives the pin low
  assign enable_fault_pin_out = 1'b0;
  assign enable_fault_pin_oe = !sink_reg;
  assign power_stage_on = switching && (ph_scaled < duty_scaled);
  assign output_overshoot_clamp = v_over && state_reg != ICS_OFF;
  assign duty_permille = duty_reg;
  assign switch_period = per_reg;
  assign level_high_sel = lvl_reg;
  assign overpower_active = opp_reg;
  assign low_power_mode = (state_reg == ICS_OFF);
  assign fault_active = sink_reg;
endmodule // ics_supervisor
`default_nettype wire

// ==== tb/ics_host_model.sv ====
// Host side of the enable/fault pin: drives enable through a series resistor.
// Assumes the device sinks the pin when its active-low enable is low.
`timescale 1ns/1ps
`default_nettype none
module ics_host_model (
  // Clock
  input wire logic core_clk,
  // Host side
  input wire logic host_enable,
  output logic [7:0] pulses_seen,
  // Pin
  input wire logic enable_fault_pin_out,
  input wire logic enable_fault_pin_oe,
  output logic pin_level
);
  logic last_reg = 1'b0;
  initial pulses_seen = 8'h00;
  // Resistor lets the device sink win over the host drive
  // Host holds the pin high to run, low for low power
  assign pin_level = enable_fault_pin_oe ? host_enable : enable_fault_pin_out;
  // Count reports only while enabled, so a host disable is not a fault
  always @(posedge core_clk) begin
    if (last_reg && !pin_level && host_enable) pulses_seen <= pulses_seen + 8'h01;
    last_reg <= pin_level;
  end
endmodule // ics_host_model
`default_nettype wire

// ==== tb/ics_supervisor_monitor.sv ====
// Checker for the supervisor: fault pulse, restart, lockout and burst limits.
// Bound to ics_supervisor; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module ics_supervisor_monitor #(
  parameter int RESTART = ics_pkg::RESTART_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Pin and flags
  input wire logic enable_fault_pin_in,
  input wire logic enable_fault_pin_out,
  input wire logic enable_fault_pin_oe,
  input wire logic input_low_flag,
  input wire logic input_high_flag,
  // Status
  input wire logic power_stage_on,
  input wire logic low_power_mode,
  input wire logic fault_active
);
  import ics_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [15:0] low_cnt_reg;
  logic [9:0] on_cnt_reg;
  logic [31:0] gap_reg;
  logic track_reg;
  always_ff @(posedge core_clk) begin
    low_cnt_reg <= enable_fault_pin_oe ? 16'h0000 : low_cnt_reg + 16'h0001;
  end
  // Saturates so a stuck stage cannot wrap back under the limit
  always_ff @(posedge core_clk) begin
    if (!power_stage_on) on_cnt_reg <= 10'h000;
    else if (on_cnt_reg != 10'h3FF) on_cnt_reg <= on_cnt_reg + 10'h001;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst || low_power_mode || power_stage_on) track_reg <= 1'b0;
    else if ($rose(enable_fault_pin_oe)) track_reg <= 1'b1;
  end
  always_ff @(posedge core_clk) begin
    gap_reg <= track_reg ? gap_reg + 32'h1 : 32'h0;
  end
  a_out_low: assert property (enable_fault_pin_out == 1'b0)
    else $error("pin data not low");
  a_off_idle: assert property (low_power_mode |-> !power_stage_on)
    else $error("switching while off");
  a_pulse_len: assert property ($rose(enable_fault_pin_oe) |-> low_cnt_reg == FAULT_PULSE_CYC)
    else $error("fault pulse length wrong");
  a_restart_min: assert property ($rose(power_stage_on) && track_reg |-> gap_reg >= RESTART - 2)
    else $error("restart too early");
  a_restart_max: assert property (track_reg |-> gap_reg <= RESTART + 60)
    else $error("restart missing");
  a_lock_stop: assert property ((input_low_flag || input_high_flag) [*8] ##0 !fault_active
    |-> !power_stage_on)
    else $error("switching in lockout");
  a_lock_resume: assert property ($fell(input_low_flag || input_high_flag) && enable_fault_pin_in
    && !low_power_mode && !fault_active |-> ##[1:60] power_stage_on)
    else $error("no resume after lockout");
  a_burst_limit: assert property (on_cnt_reg <= ON_MAX_CYC)
    else $error("burst on too long");
endmodule // ics_supervisor_monitor
bind ics_supervisor ics_supervisor_monitor #(.RESTART(RESTART)) ics_supervisor_monitor_i (
  .core_clk, .sys_rst, .enable_fault_pin_in, .enable_fault_pin_out, .enable_fault_pin_oe,
  .input_low_flag, .input_high_flag, .power_stage_on, .low_power_mode, .fault_active);
`default_nettype wire

// ==== tb/tb_ics_supervisor.sv ====
// Testbench for the supervisor: enable, select, timeout, lockout, burst and faults.
// Assumes ics_pkg constants; soft-start, restart and deglitch counts shortened.
`timescale 1ns/1ps
`default_nettype none
module tb_ics_supervisor;
  import ics_pkg::*;
  localparam int SS_T = 2000;
  localparam int RST_T = 3000;
  localparam int DG = 20;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic host_en = 1'b0;
  logic input_low_flag = 1'b0, input_high_flag = 1'b0, output_startup_flag = 1'b0;
  logic output_regulated_flag = 1'b0, output_lower_band_flag = 1'b0;
  logic output_upper_band_flag = 1'b0, level_select_in = 1'b1;
  logic [3:0] flt = 4'h0;
  logic enable_fault_pin_in, enable_fault_pin_out, enable_fault_pin_oe, power_stage_on;
  logic output_overshoot_clamp, level_high_sel, overpower_active, low_power_mode, fault_active;
  logic [9:0] duty_permille;
  logic [7:0] switch_period, pulses;
  int errors = 0;
  int tests_run = 0;
  int n;
  ics_supervisor #(.SS_TIMEOUT(SS_T), .RESTART(RST_T), .DEGLITCH(DG)) ics_supervisor_i (
    .core_clk, .sys_rst, .enable_fault_pin_in, .enable_fault_pin_out, .enable_fault_pin_oe,
    .input_low_flag, .input_high_flag, .output_startup_flag, .output_regulated_flag,
    .output_lower_band_flag, .output_upper_band_flag, .output_under_flag(flt[0]),
    .output_over_flag(flt[2]), .primary_overtemp_flag(flt[1]),
    .secondary_overtemp_flag(flt[3]), .level_select_in, .power_stage_on,
    .output_overshoot_clamp, .duty_permille, .switch_period, .level_high_sel,
    .overpower_active, .low_power_mode, .fault_active);
  ics_host_model ics_host_model_i (.core_clk, .host_enable(host_en), .pulses_seen(pulses),
    .enable_fault_pin_out, .enable_fault_pin_oe, .pin_level(enable_fault_pin_in));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return power_stage_on === 1'b1;
      1: return fault_active === 1'b1;
      2: return fault_active === 1'b0;
      default: return overpower_active === 1'b1;
    endcase
  endfunction
  // Bounded wait; running out ends the run
  task automatic wt(input int s, input int lim, output int cnt);
    cnt = 0;
    while (!sig(s) && cnt < lim) begin
      @(negedge core_clk);
      cnt++;
    end
    if (cnt >= lim) begin
      errors++;
      $display("Error at %0t: wait %0d ran out", $time, s);
      results();
    end
  endtask
  task automatic quiet(input int k, input string m);
    int hi = 0;
    repeat (k) begin
      @(negedge core_clk);
      if (power_stage_on !== 1'b0) hi++;
    end
    check(hi == 0, m);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_enable();
    quiet(10, "switching while disabled");
    check(low_power_mode === 1'b1, "not in low power");
    level_select_in = 1'b0;
    host_en = 1'b1;
    wt(0, 60, n);
    check(duty_permille === DUTY_START, "start duty");
    repeat (30) @(negedge core_clk);
    check(level_high_sel === 1'b1, "ground select");
    output_startup_flag = 1'b1;
    level_select_in = 1'b1;
    repeat (20) @(negedge core_clk);
    check(level_high_sel === 1'b1, "select not ignored");
    host_en = 1'b0;
    output_startup_flag = 1'b0;
    repeat (10) @(negedge core_clk);
    host_en = 1'b1;
    repeat (30) @(negedge core_clk);
    check(level_high_sel === 1'b0, "no resample after toggle");
    check(duty_permille <= DUTY_CAP, "duty over cap");
  endtask
  task automatic t_timeout();
    logic [7:0] p0;
    p0 = pulses;
    wt(1, SS_T + 100, n);
    check(n >= SS_T - 60, "timeout early");
    wt(2, FAULT_PULSE_CYC + 10, n);
    check(n == FAULT_PULSE_CYC, "pulse length");
    check(pulses === p0 + 8'h01, "host missed pulse");
    wt(0, RST_T + 60, n);
    check(n >= RST_T - 2, "restart early");
    wt(1, SS_T + 100, n);
    output_regulated_flag = 1'b1;
    wt(2, FAULT_PULSE_CYC + 10, n);
    wt(0, RST_T + 60, n);
    repeat (100) @(negedge core_clk);
  endtask
  task automatic t_lockout();
    output_lower_band_flag = 1'b1;
    for (int i = 0; i < 2; i++) begin
      repeat (50) @(negedge core_clk);
      {input_high_flag, input_low_flag} = 2'(1 << i);
      repeat (10) @(negedge core_clk);
      quiet(40, "switching in lockout");
      check(fault_active === 1'b0, "lockout reported");
      {input_high_flag, input_low_flag} = 2'b00;
      wt(0, 60, n);
    end
    output_lower_band_flag = 1'b0;
    output_upper_band_flag = 1'b1;
    repeat (100) @(negedge core_clk);
  endtask
  task automatic t_burst();
    quiet(100, "on at upper band");
    output_upper_band_flag = 1'b0;
    output_lower_band_flag = 1'b1;
    wt(0, 20, n);
    wt(3, ON_MAX_CYC + 50, n);
    check(n >= ON_MAX_CYC - 20, "overpower early");
    quiet(OFF_MIN_CYC - 5, "off time short");
    wt(0, 40, n);
    check(switch_period >= PERIOD_LO && switch_period <= PERIOD_HI, "sweep span");
    output_lower_band_flag = 1'b0;
    output_upper_band_flag = 1'b1;
    repeat (50) @(negedge core_clk);
  endtask
  task automatic t_faults();
    for (int i = 0; i < 4; i++) begin
      flt = 4'(1 << i);
      repeat (8) @(negedge core_clk);
      if (i == 2) check(output_overshoot_clamp === 1'b1, "no clamp");
      wt(1, DG + 40, n);
      check(n >= DG - 10, "deglitch short");
      flt = 4'h0;
      wt(2, FAULT_PULSE_CYC + 10, n);
      check(n == FAULT_PULSE_CYC, "pulse length");
      wt(0, RST_T + 60, n);
      check(n >= RST_T - 2, "restart early");
      repeat (100) @(negedge core_clk);
    end
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    sys_rst = 1'b0;
    t_enable();
    t_timeout();
    t_lockout();
    t_burst();
    t_faults();
    results();
  end
endmodule // tb_ics_supervisor
`default_nettype wire
